// ===== hw/ssp_pkg.sv
// register map, field positions and reset values of the sync serial port
// assumes a 32-bit apb slave with byte addresses on paddr
package ssp_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_RX_STAT = 8'h00;
  localparam logic [7:0] ADDR_RX_HOLD = 8'h04;
  localparam logic [7:0] ADDR_TX_STAT = 8'h08;
  localparam logic [7:0] ADDR_BAUD = 8'h0c;
  localparam logic [7:0] ADDR_DIV_HI = 8'h10;
  localparam logic [7:0] ADDR_DIV_LO = 8'h14;
  localparam logic [7:0] ADDR_TX_HOLD = 8'h18;
  localparam logic [7:0] ADDR_INT_CTL = 8'h1c;
  // receive status/control fields
  localparam int RS_SERIAL_PORT_ENABLE = 7;
  localparam int RS_RX9 = 6;
  localparam int RS_SINGLE_RECEIVE_ENABLE = 5;
  localparam int RS_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int RS_OVERRUN_FLAG = 1;
  localparam int RS_RECEIVED_NINTH_BIT = 0;
  // transmit status/control fields
  localparam int TS_CLOCK_SOURCE_SELECT = 7;
  localparam int TS_TX9 = 6;
  localparam int TS_TRANSMIT_ENABLE_BIT = 5;
  localparam int TS_SYNC = 4;
  localparam int TS_HIGH_SPEED_BAUD = 2;
  localparam int TS_TRMT = 1;
  localparam int TS_NINTH_TRANSMIT_BIT = 0;
  // baud control field
  localparam int BC_WIDE_BAUD_DIVISOR = 3;
  // interrupt control fields
  localparam int IC_RXF = 0;
  localparam int IC_TXF = 1;
  localparam int IC_RXIE = 2;
  localparam int IC_TRANSMIT_INTERRUPT_ENABLE = 3;
  localparam int IC_PERIPHERAL_INTERRUPT_ENABLE = 4;
  localparam int IC_GIE = 5;
  // reset values and character lengths
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
endpackage

// ===== hw/ssp_top.sv
// synchronous half-duplex serial port with apb registers
// assumes clock at 100 MHz; link pins come from another clock domain
`timescale 1ns/1ps
module ssp_top (
  input wire logic clock, // system clock
  input wire logic rst, // async reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic dataIn, // data line level
  output logic dataOut, // data line drive value
  output logic dataOe, // data line drive enable
  input wire logic clkIn, // clock line level
  output logic clkOut, // clock line drive value
  output logic clkOe, // clock line drive enable
  output logic wakeReq, // interrupt request, wakes from sleep
  output logic vectorReq // request with global enable set
);
  logic serial_port_enable_q, rx9_q, single_receive_enable_q, continuous_receive_enable_q, overrun_flag_q;
  logic clock_source_select_q, tx9_q, transmit_enable_bit_q, sync_q, high_speed_baud_q, ninth_transmit_bit_q, wide_baud_divisor_q;
  logic rxIe_q, transmit_interrupt_enable_q, peripheral_interrupt_enable_q, gIe_q;
  logic [7:0] divHi_q, divLo_q;
  logic [31:0] rdata_q;
  logic err_q, wake_q, vector_q;
  logic c1_q, c2_q, c3_q, d1_q, d2_q;
  logic [8:0] fifo_q [2];
  logic wrPtr_q, rdPtr_q;
  logic [1:0] fifoCnt_q;
  logic [8:0] rsr_q, charWord;
  logic [3:0] rxCnt_q, rxBits, txLeft_q;
  logic [8:0] thr_q, tsr_q;
  logic thrFull_q, dataOut_q, clkGen_q;
  logic [15:0] baudCnt_q, divisor;
  logic wrEn, rdEn, wrRx, wrTx, wrHold, pop, unitOn, master, rxEnable;
  logic txActive, load, run, tick, lead, trail, charDone, push, crenFall;
  logic rxFlag, txFlag, fifoFull;

  // bus strobes
  assign wrEn = psel & penable & pwrite;
  assign rdEn = psel & penable & ~pwrite;
  assign wrRx = wrEn && paddr == ssp_pkg::ADDR_RX_STAT;
  assign wrTx = wrEn && paddr == ssp_pkg::ADDR_TX_STAT;
  assign wrHold = wrEn && paddr == ssp_pkg::ADDR_TX_HOLD;
  assign pop = rdEn && paddr == ssp_pkg::ADDR_RX_HOLD && fifoCnt_q != 2'd0;
  assign crenFall = wrRx & continuous_receive_enable_q & ~pwdata[ssp_pkg::RS_CONTINUOUS_RECEIVE_ENABLE];
  assign pready = 1'b1;
  assign pslverr = psel & penable & err_q;
  assign prdata = rdata_q;

  // operating mode decode
  assign unitOn = serial_port_enable_q & sync_q;
  assign master = unitOn & clock_source_select_q;
  assign rxEnable = unitOn & (single_receive_enable_q | continuous_receive_enable_q) & ~overrun_flag_q;
  assign txActive = unitOn & transmit_enable_bit_q & ~single_receive_enable_q & ~continuous_receive_enable_q;
  assign rxBits = rx9_q ? ssp_pkg::BITS_9 : ssp_pkg::BITS_8;
  assign fifoFull = fifoCnt_q == 2'd2;
  assign rxFlag = fifoCnt_q != 2'd0;
  assign txFlag = ~thrFull_q;

  // receive control register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      serial_port_enable_q <= 1'b0;
      rx9_q <= 1'b0;
      single_receive_enable_q <= 1'b0;
      continuous_receive_enable_q <= 1'b0;
    end else if (wrRx) begin
      serial_port_enable_q <= pwdata[ssp_pkg::RS_SERIAL_PORT_ENABLE];
      rx9_q <= pwdata[ssp_pkg::RS_RX9];
      single_receive_enable_q <= pwdata[ssp_pkg::RS_SINGLE_RECEIVE_ENABLE];
      continuous_receive_enable_q <= pwdata[ssp_pkg::RS_CONTINUOUS_RECEIVE_ENABLE];
    end else if (charDone) begin
      single_receive_enable_q <= 1'b0;
    end
  end

  // transmit, baud and interrupt control registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      {clock_source_select_q, tx9_q, transmit_enable_bit_q, sync_q, high_speed_baud_q, ninth_transmit_bit_q} <= 6'h00;
      {wide_baud_divisor_q, rxIe_q, transmit_interrupt_enable_q, peripheral_interrupt_enable_q, gIe_q} <= 5'h00;
      divHi_q <= ssp_pkg::RST_BYTE;
      divLo_q <= ssp_pkg::RST_BYTE;
    end else if (wrTx) begin
      clock_source_select_q <= pwdata[ssp_pkg::TS_CLOCK_SOURCE_SELECT];
      tx9_q <= pwdata[ssp_pkg::TS_TX9];
      transmit_enable_bit_q <= pwdata[ssp_pkg::TS_TRANSMIT_ENABLE_BIT];
      sync_q <= pwdata[ssp_pkg::TS_SYNC];
      high_speed_baud_q <= pwdata[ssp_pkg::TS_HIGH_SPEED_BAUD];
      ninth_transmit_bit_q <= pwdata[ssp_pkg::TS_NINTH_TRANSMIT_BIT];
    end else if (wrEn && paddr == ssp_pkg::ADDR_BAUD) begin
      wide_baud_divisor_q <= pwdata[ssp_pkg::BC_WIDE_BAUD_DIVISOR];
    end else if (wrEn && paddr == ssp_pkg::ADDR_DIV_HI) begin
      divHi_q <= pwdata[7:0];
    end else if (wrEn && paddr == ssp_pkg::ADDR_DIV_LO) begin
      divLo_q <= pwdata[7:0];
    end else if (wrEn && paddr == ssp_pkg::ADDR_INT_CTL) begin
      rxIe_q <= pwdata[ssp_pkg::IC_RXIE];
      transmit_interrupt_enable_q <= pwdata[ssp_pkg::IC_TRANSMIT_INTERRUPT_ENABLE];
      peripheral_interrupt_enable_q <= pwdata[ssp_pkg::IC_PERIPHERAL_INTERRUPT_ENABLE];
      gIe_q <= pwdata[ssp_pkg::IC_GIE];
    end
  end

  // read data captured in the setup cycle, unmapped gives error
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0;
      err_q <= 1'b0;
    end else if (psel && !penable) begin
      err_q <= 1'b0;
      if (paddr == ssp_pkg::ADDR_RX_STAT) begin
        rdata_q <= {24'h0, serial_port_enable_q, rx9_q, single_receive_enable_q, continuous_receive_enable_q, 2'b00, overrun_flag_q,
          fifo_q[rdPtr_q][8]};
      end else if (paddr == ssp_pkg::ADDR_RX_HOLD) begin
        rdata_q <= {24'h0, fifo_q[rdPtr_q][7:0]};
      end else if (paddr == ssp_pkg::ADDR_TX_STAT) begin
        rdata_q <= {24'h0, clock_source_select_q, tx9_q, transmit_enable_bit_q, sync_q, 1'b0, high_speed_baud_q,
          txLeft_q == 4'h0, ninth_transmit_bit_q};
      end else if (paddr == ssp_pkg::ADDR_BAUD) begin
        rdata_q <= {28'h0, wide_baud_divisor_q, 3'b000};
      end else if (paddr == ssp_pkg::ADDR_DIV_HI) begin
        rdata_q <= {24'h0, divHi_q};
      end else if (paddr == ssp_pkg::ADDR_DIV_LO) begin
        rdata_q <= {24'h0, divLo_q};
      end else if (paddr == ssp_pkg::ADDR_TX_HOLD) begin
        rdata_q <= 32'h0;
      end else if (paddr == ssp_pkg::ADDR_INT_CTL) begin
        rdata_q <= {26'h0, gIe_q, peripheral_interrupt_enable_q, transmit_interrupt_enable_q, rxIe_q, txFlag, rxFlag};
      end else begin
        rdata_q <= 32'h0;
        err_q <= 1'b1;
      end
    end
  end

  // two-flop synchronisers for the link pins, plus clock edge history
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      {c1_q, c2_q, c3_q, d1_q, d2_q} <= 5'h00;
    end else begin
      c1_q <= clkIn;
      c2_q <= c1_q;
      c3_q <= c2_q;
      d1_q <= dataIn;
      d2_q <= d1_q;
    end
  end

  // baud generator: one tick per half period of the master clock
  assign divisor = wide_baud_divisor_q ? {divHi_q, divLo_q} : {8'h00, divLo_q};
  assign run = master & (rxEnable | (txActive & txLeft_q != 4'h0));
  assign tick = run && baudCnt_q == divisor;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      baudCnt_q <= 16'h0;
      clkGen_q <= 1'b0;
    end else if (!run) begin
      baudCnt_q <= 16'h0;
      clkGen_q <= 1'b0; // clock stops at once, partial character dropped
    end else if (tick) begin
      baudCnt_q <= 16'h0;
      clkGen_q <= ~clkGen_q;
    end else begin
      baudCnt_q <= baudCnt_q + 16'h1;
    end
  end

  // leading and trailing edges from own clock or from the clock line
  assign lead = master ? tick & ~clkGen_q : unitOn & c2_q & ~c3_q;
  assign trail = master ? tick & clkGen_q : unitOn & ~c2_q & c3_q;
  assign clkOut = clkGen_q;
  assign clkOe = master;

  // receive shift register, one bit per trailing edge
  always_comb begin
    charWord = rsr_q;
    charWord[rxCnt_q] = d2_q;
  end
  assign charDone = trail && rxEnable && rxCnt_q == rxBits - 4'h1;
  assign push = charDone & ~fifoFull;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rsr_q <= 9'h0;
      rxCnt_q <= 4'h0;
    end else if (!rxEnable || charDone) begin
      rsr_q <= 9'h0;
      rxCnt_q <= 4'h0;
    end else if (trail) begin
      rsr_q <= charWord;
      rxCnt_q <= rxCnt_q + 4'h1;
    end
  end

  // two-character receive buffer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fifo_q[0] <= 9'h0;
      fifo_q[1] <= 9'h0;
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      fifoCnt_q <= 2'd0;
    end else if (!serial_port_enable_q) begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      fifoCnt_q <= 2'd0;
    end else begin
      if (push) begin
        fifo_q[wrPtr_q] <= charWord;
        wrPtr_q <= ~wrPtr_q;
      end
      if (pop) begin
        rdPtr_q <= ~rdPtr_q;
      end
      fifoCnt_q <= fifoCnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // overrun flag, a new overrun wins over any clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      overrun_flag_q <= 1'b0;
    end else if (charDone && fifoFull) begin
      overrun_flag_q <= 1'b1;
    end else if (!serial_port_enable_q || crenFall || (pop && !continuous_receive_enable_q)) begin
      overrun_flag_q <= 1'b0;
    end
  end

  // transmit holding register
  assign load = txActive && thrFull_q && txLeft_q == 4'h0;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      thr_q <= 9'h0;
      thrFull_q <= 1'b0;
    end else if (!serial_port_enable_q) begin
      thrFull_q <= 1'b0;
    end else if (wrHold) begin
      thr_q <= {ninth_transmit_bit_q, pwdata[7:0]};
      thrFull_q <= 1'b1;
    end else if (load) begin
      thrFull_q <= 1'b0;
    end
  end

  // transmit shift register: drive on leading, count on trailing edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tsr_q <= 9'h0;
      txLeft_q <= 4'h0;
      dataOut_q <= 1'b0;
    end else if (!txActive) begin
      txLeft_q <= 4'h0;
    end else if (load) begin
      tsr_q <= thr_q;
      txLeft_q <= tx9_q ? ssp_pkg::BITS_9 : ssp_pkg::BITS_8;
    end else if (lead && txLeft_q != 4'h0) begin
      dataOut_q <= tsr_q[0];
      tsr_q <= {1'b0, tsr_q[8:1]};
    end else if (trail && txLeft_q != 4'h0) begin
      txLeft_q <= txLeft_q - 4'h1;
    end
  end
  assign dataOut = dataOut_q;
  assign dataOe = txActive;

  // interrupt request and vector outputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wake_q <= 1'b0;
      vector_q <= 1'b0;
    end else begin
      wake_q <= peripheral_interrupt_enable_q & ((rxFlag & rxIe_q) | (txFlag & transmit_interrupt_enable_q));
      vector_q <= gIe_q & peripheral_interrupt_enable_q & ((rxFlag & rxIe_q) | (txFlag & transmit_interrupt_enable_q));
    end
  end
  assign wakeReq = wake_q;
  assign vectorReq = vector_q;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence ovrHit;
    charDone && fifoFull;
  endsequence
  sequence heldSecond;
    txActive && thrFull_q && txLeft_q != 4'h0 && !wrHold;
  endsequence

  a_ovr_sets: assert property (ovrHit |=> overrun_flag_q)
    else $error("overrun not flagged");
  a_ovr_keeps: assert property ((ovrHit and !pop) |=> fifoCnt_q == 2'd2 &&
    $stable(fifo_q[0]) && $stable(fifo_q[1]))
    else $error("buffer overwritten on overrun");
  a_single_clear: assert property (charDone && !wrRx |=> !single_receive_enable_q)
    else $error("single receive not cleared");
  a_rx_flag: assert property (push && !pop && serial_port_enable_q |=> rxFlag)
    else $error("receive flag not set");
  a_serial_port_enable_reset: assert property (!serial_port_enable_q |=> fifoCnt_q == 2'd0 &&
    !thrFull_q && !overrun_flag_q)
    else $error("unit not reset");
  a_slave_clk: assert property (unitOn && !clock_source_select_q |-> !clkOe)
    else $error("slave drives clock");
  a_master_clk: assert property (serial_port_enable_q && sync_q && clock_source_select_q |-> clkOe)
    else $error("master not driving clock");
  a_tx_hold: assert property (heldSecond |=> !txFlag)
    else $error("transmit flag set while held");
  a_tx_load: assert property (load |=> txLeft_q == (tx9_q ? 4'h9 : 4'h8)
    && (!thrFull_q || $past(wrHold)))
    else $error("holding word not loaded");
  a_rx_shift: assert property (trail && rxEnable && !charDone |=>
    rxCnt_q == $past(rxCnt_q) + 4'h1)
    else $error("receive bit count wrong");
  a_wake_vec: assert property (vectorReq |-> wakeReq && gIe_q)
    else $error("vector without wake");
  a_tx_bit: assert property (lead && txActive && txLeft_q != 4'h0 && !load |=>
    dataOut == $past(tsr_q[0]))
    else $error("transmit bit not driven");
endmodule

// ===== verif/ssp_partner.sv
// far-side synchronous serial device for the sync serial port bench
// assumes the bench resolves both shared lines from all drive enables
`timescale 1ns/1ps
module ssp_partner (
  input wire logic clkLine, // resolved clock line level
  input wire logic dataLine, // resolved data line level
  output logic clkDrv, // clock driven when the port is a clock slave
  output logic dataDrv // data driven when the port does not drive
);
  // clock stands low between frames, data idles high
  initial begin
    clkDrv = 1'b0;
    dataDrv = 1'b1;
  end

  // one frame as clock master: 160 ns period, lsb first
  task automatic slave_frame(input int n, input logic [8:0] sendW, output logic [8:0] gotW);
    gotW = 9'h000;
    for (int i = 0; i < n; i++) begin
      clkDrv = 1'b1;
      dataDrv = sendW[i];
      #80;
      clkDrv = 1'b0;
      gotW[i] = dataLine;
      #80;
    end
    dataDrv = ~dataDrv; // released line must not keep the last bit
  endtask

  // feed bits to a master port: change data on each leading edge
  task automatic master_feed(input int n, input logic [26:0] sendW);
    for (int i = 0; i < n; i++) begin
      @(posedge clkLine);
      dataDrv = sendW[i];
    end
    @(negedge clkLine);
    dataDrv = ~dataDrv;
  endtask
endmodule

// ===== verif/ssp_top_bench.sv
// self-checking bench for the sync serial port: apb master plus link partner
// assumes ssp_pkg and ssp_top compiled first; no sleep model beyond request pins
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checksDone++; if ((got) !== (exp)) begin errTotal++; \
  $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module ssp_top_bench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, dataOut, dataOe, clkOut, clkOe, wakeReq, vectorReq;
  logic pClk, pData, rdErr;
  logic [7:0] rd;
  logic [8:0] got;
  int errTotal = 0;
  int checksDone = 0;
  // shared line levels from the port's drive enables, partner drive otherwise; pins are purely digital
  wire clkWire = clkOe ? clkOut : pClk;
  wire dataWire = dataOe ? dataOut : pData;

  ssp_top u_ssp_top (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dataIn(dataWire), .dataOut(dataOut), .dataOe(dataOe),
    .clkIn(clkWire), .clkOut(clkOut), .clkOe(clkOe), .wakeReq(wakeReq),
    .vectorReq(vectorReq));
  ssp_partner u_ssp_partner (.clkLine(clkWire), .dataLine(dataWire), .clkDrv(pClk),
    .dataDrv(pData));

  // 100 MHz system clock
  initial begin
    forever #5 clock = ~clock;
  end

  // verdict and end of run
  task summarize;
    $display("mismatches %0d checks %0d", errTotal, checksDone);
    if (errTotal == 0 && checksDone > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // one apb transfer; read data and error taken at the ready edge
  task apb(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= {24'h000000, wd};
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      errTotal++;
      summarize();
    end
    rd = prdata[7:0];
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // read a register until all mask bits are set, bounded
  task poll(input logic [7:0] addr, input logic [7:0] mask);
    int n;
    n = 0;
    do begin
      apb(1'b0, addr, 8'h00);
      n++;
    end while ((rd & mask) !== mask && n < 500);
    `CHK("poll", mask, rd & mask)
  endtask

  // pin drive enables, looked at away from the clock edge
  task pins(input logic expClk, input logic expData);
    @(negedge clock);
    `CHK("clkOe", expClk, clkOe)
    `CHK("dataOe", expData, dataOe)
  endtask

  task reset_regs;
    apb(1'b0, ssp_pkg::ADDR_RX_STAT, 8'h00);
    `CHK("rxStat", 8'h00, rd)
    apb(1'b0, ssp_pkg::ADDR_INT_CTL, 8'h00);
    `CHK("intCtl", 8'h02, rd)
    apb(1'b1, ssp_pkg::ADDR_DIV_HI, 8'h5a);
    apb(1'b0, ssp_pkg::ADDR_DIV_HI, 8'h00);
    `CHK("divHi", 8'h5a, rd)
    apb(1'b0, 8'h20, 8'h00);
    `CHK("unmappedErr", 1'b1, rdErr)
    `CHK("unmappedData", 8'h00, rd)
  endtask

  task master_single;
    apb(1'b1, ssp_pkg::ADDR_DIV_HI, 8'h00);
    apb(1'b1, ssp_pkg::ADDR_DIV_LO, 8'h04);
    apb(1'b1, ssp_pkg::ADDR_TX_STAT, 8'h90);
    apb(1'b1, ssp_pkg::ADDR_RX_STAT, 8'h80);
    pins(1'b1, 1'b0);
    apb(1'b1, ssp_pkg::ADDR_RX_STAT, 8'ha0);
    u_ssp_partner.master_feed(8, 27'h00000a5);
    poll(ssp_pkg::ADDR_INT_CTL, 8'h01);
    apb(1'b0, ssp_pkg::ADDR_RX_STAT, 8'h00);
    `CHK("singleCleared", 8'h80, rd)
    `CHK("clkIdle", 1'b0, clkOut)
    apb(1'b0, ssp_pkg::ADDR_RX_HOLD, 8'h00);
    `CHK("rxHold", 8'ha5, rd)
  endtask

  task master_overrun;
    apb(1'b1, ssp_pkg::ADDR_RX_STAT, 8'hd0);
    u_ssp_partner.master_feed(27, {9'h0ff, 9'h05a, 9'h1c3});
    poll(ssp_pkg::ADDR_RX_STAT, 8'h02);
    apb(1'b0, ssp_pkg::ADDR_RX_STAT, 8'h00);
    `CHK("rxStatOver", 8'hd3, rd)
    apb(1'b1, ssp_pkg::ADDR_INT_CTL, 8'h14);
    repeat (2) @(negedge clock);
    `CHK("wakeRx", 1'b1, wakeReq)
    `CHK("noVector", 1'b0, vectorReq)
    apb(1'b1, ssp_pkg::ADDR_INT_CTL, 8'h34);
    repeat (2) @(negedge clock);
    `CHK("vector", 1'b1, vectorReq)
    apb(1'b1, ssp_pkg::ADDR_RX_STAT, 8'hc0);
    apb(1'b0, ssp_pkg::ADDR_RX_STAT, 8'h00);
    `CHK("overClear", 8'hc1, rd)
    apb(1'b0, ssp_pkg::ADDR_RX_HOLD, 8'h00);
    `CHK("first", 8'hc3, rd)
    apb(1'b0, ssp_pkg::ADDR_RX_STAT, 8'h00);
    `CHK("ninthBit", 8'hc0, rd)
    apb(1'b0, ssp_pkg::ADDR_RX_HOLD, 8'h00);
    `CHK("second", 8'h5a, rd)
    apb(1'b1, ssp_pkg::ADDR_INT_CTL, 8'h00);
  endtask

  task slave_tx;
    apb(1'b1, ssp_pkg::ADDR_RX_STAT, 8'h80);
    apb(1'b1, ssp_pkg::ADDR_TX_STAT, 8'h30);
    apb(1'b1, ssp_pkg::ADDR_INT_CTL, 8'h18);
    apb(1'b1, ssp_pkg::ADDR_TX_HOLD, 8'h3c);
    apb(1'b1, ssp_pkg::ADDR_TX_HOLD, 8'h81);
    apb(1'b0, ssp_pkg::ADDR_INT_CTL, 8'h00);
    `CHK("txFlagHeld", 8'h18, rd)
    pins(1'b0, 1'b1);
    `CHK("noWake", 1'b0, wakeReq)
    u_ssp_partner.slave_frame(8, 9'h000, got);
    `CHK("txFirst", 9'h03c, got)
    poll(ssp_pkg::ADDR_INT_CTL, 8'h02);
    repeat (2) @(negedge clock);
    `CHK("wakeTx", 1'b1, wakeReq)
    `CHK("noVectorTx", 1'b0, vectorReq)
    u_ssp_partner.slave_frame(8, 9'h000, got);
    `CHK("txSecond", 9'h081, got)
    apb(1'b1, ssp_pkg::ADDR_TX_STAT, 8'h71);
    apb(1'b1, ssp_pkg::ADDR_TX_HOLD, 8'h55);
    u_ssp_partner.slave_frame(9, 9'h000, got);
    `CHK("txNine", 9'h155, got)
    apb(1'b1, ssp_pkg::ADDR_TX_STAT, 8'h10);
    apb(1'b1, ssp_pkg::ADDR_TX_HOLD, 8'hff);
    pins(1'b0, 1'b0);
  endtask

  task slave_rx;
    apb(1'b1, ssp_pkg::ADDR_INT_CTL, 8'h00);
    apb(1'b1, ssp_pkg::ADDR_RX_STAT, 8'h90);
    u_ssp_partner.slave_frame(8, 9'h096, got);
    poll(ssp_pkg::ADDR_INT_CTL, 8'h01);
    pins(1'b0, 1'b0);
    apb(1'b0, ssp_pkg::ADDR_RX_HOLD, 8'h00);
    `CHK("slaveRx", 8'h96, rd)
    u_ssp_partner.slave_frame(8, 9'h069, got);
    poll(ssp_pkg::ADDR_INT_CTL, 8'h01);
    apb(1'b1, ssp_pkg::ADDR_RX_STAT, 8'h00);
    apb(1'b0, ssp_pkg::ADDR_INT_CTL, 8'h00);
    `CHK("offFlag", 1'b0, rd[0])
  endtask

  // main sequence
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    reset_regs();
    master_single();
    master_overrun();
    slave_tx();
    slave_rx();
    summarize();
  end

  // hang guard
  initial begin
    repeat (60000) @(posedge clock);
    errTotal++;
    summarize();
  end
endmodule
